// ==== hw/qdsl_top.sv ====
// Quad DAC serial loader: shift register, input and DAC registers, serial echo
`timescale 1ns/1ns
`default_nettype none
`include "qdsl_map.svh"
module qdsl_top
  import qdsl_pkg::*;
#(
  parameter int CODE_W   = `QDSL_CODE_W,
  parameter int CHANNELS = `QDSL_CHANNELS
) (
  input  wire logic                             clk_in,
  input  wire logic                             reset_in,
  input  wire logic                             shift_clk_in,
  input  wire logic                             select_n_in,
  input  wire logic                             serial_in,
  input  wire logic                             load_all_strobe_n_in,
  output logic                                  serial_out,
  output logic                                  serial_out_oe_out,
  output logic [CHANNELS-1:0][CODE_W-1:0]       dac_codes_out,
  output qdsl_edge_t                            out_edge_out
);
  // ==========================================================================
  // Synchronisers
  logic       sel_n_s;
  logic       strobe_n_s;
  logic       rst_link;
  logic       edge_link;
  qdsl_edge_t edge_r;
  qdsl_edge_t edge_nxt;

  qdsl_sync #(.WIDTH(2), .RESET_VAL(3)) u_pin_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({select_n_in, load_all_strobe_n_in}),
    .sync_out ({sel_n_s, strobe_n_s})
  );

  qdsl_sync #(.WIDTH(1), .RESET_VAL(0)) u_edge_sync (
    .clk_in   (shift_clk_in),
    .reset_in (1'b0),
    .async_in (edge_r),
    .sync_out (edge_link)
  );

  qdsl_sync #(.WIDTH(1), .RESET_VAL(1)) u_rst_sync (
    .clk_in   (shift_clk_in),
    .reset_in (1'b0),
    .async_in (reset_in),
    .sync_out (rst_link)
  );

  // ==========================================================================
  // Link domain: shift register and serial output
  logic [`QDSL_FRAME_W-1:0] shift_r;
  logic [`QDSL_FRAME_W-1:0] shift_nxt;
  logic                     fall_out_r;
  logic                     fall_out_nxt;

  always_comb begin
    shift_nxt    = shift_r;
    if (!select_n_in) begin
      shift_nxt = {shift_r[`QDSL_FRAME_W-2:0], serial_in};
    end
    fall_out_nxt = shift_r[`QDSL_FRAME_W-1];
  end

  always_ff @(posedge shift_clk_in) begin
    if (rst_link) begin
      shift_r <= `QDSL_FRAME_RESET;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Half-cycle later copy for falling-edge output timing
  always_ff @(negedge shift_clk_in) begin
    fall_out_r <= fall_out_nxt;
  end

  // Idle level high while disabled
  assign serial_out        = !serial_out_oe_out ? 1'b1 :
                             (edge_link ? fall_out_r : shift_r[`QDSL_FRAME_W-1]);
  assign serial_out_oe_out = !sel_n_s;

  // ==========================================================================
  // System domain: frame decode, input and DAC registers
  function automatic logic [CHANNELS-1:0] chan_hit(input qdsl_chan_t ch);
    chan_hit = CHANNELS'(1) << ch;
  endfunction : chan_hit

  logic                              sel_n_prev_r;
  logic                              frame_end;
  qdsl_chan_t                        f_addr;
  qdsl_cmd_t                         f_cmd;
  logic [CODE_W-1:0]                 f_code;
  logic [CHANNELS-1:0]               f_hit;
  logic [CHANNELS-1:0][CODE_W-1:0]   in_r;
  logic [CHANNELS-1:0][CODE_W-1:0]   in_nxt;
  logic [CHANNELS-1:0][CODE_W-1:0]   dac_r;
  logic [CHANNELS-1:0][CODE_W-1:0]   dac_nxt;
  logic                              update_all;

  // Shift register is frozen while select is high, so it is read after the edge
  assign frame_end = sel_n_s && !sel_n_prev_r;
  assign f_addr    = shift_r[`QDSL_ADDR_MSB:`QDSL_ADDR_LSB];
  assign f_cmd     = shift_r[`QDSL_CMD_MSB:`QDSL_CMD_LSB];
  assign f_code    = shift_r[`QDSL_CODE_MSB:0];
  assign f_hit     = chan_hit(f_addr);

  always_comb begin
    in_nxt     = in_r;
    dac_nxt    = dac_r;
    edge_nxt   = edge_r;
    update_all = 1'b0;
    if (frame_end) begin
      unique case (f_cmd)
        `QDSL_CMD_LOAD_IN: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (f_hit[i]) in_nxt[i] = f_code;
          end
        end
        `QDSL_CMD_LOAD_UP: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (f_hit[i]) in_nxt[i] = f_code;
          end
          update_all = 1'b1;
        end
        `QDSL_CMD_SPECIAL: begin
          if (f_addr == `QDSL_ADDR_FALL) begin
            edge_nxt   = QDSL_EDGE_FALL;
            update_all = 1'b1;
          end else if (f_addr == `QDSL_ADDR_RISE) begin
            edge_nxt   = QDSL_EDGE_RISE;
            update_all = 1'b1;
          end
        end
        `QDSL_CMD_NOP: begin
        end
      endcase
    end
    if (update_all) dac_nxt = in_nxt;
    if (!strobe_n_s) dac_nxt = in_r;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sel_n_prev_r <= 1'b1;
      in_r         <= {CHANNELS{CODE_W'(`QDSL_CODE_RESET)}};
      dac_r        <= {CHANNELS{CODE_W'(`QDSL_CODE_RESET)}};
      edge_r       <= QDSL_EDGE_RISE;
    end else begin
      sel_n_prev_r <= sel_n_s;
      in_r         <= in_nxt;
      dac_r        <= dac_nxt;
      edge_r       <= edge_nxt;
    end
  end

  // Unsigned straight binary code to the converter
  assign dac_codes_out = dac_r;
  assign out_edge_out  = edge_r;

  // ==========================================================================
  // Assertions
  // Consecutive shifting edges, saturating at one frame
  localparam int ECHO_CNT_W = $clog2(`QDSL_FRAME_W + 1);
  logic [ECHO_CNT_W-1:0] echo_cnt_r;
  logic [ECHO_CNT_W-1:0] echo_cnt_nxt;
  logic                  echo_full;

  assign echo_full = (echo_cnt_r == ECHO_CNT_W'(`QDSL_FRAME_W));

  always_comb begin
    echo_cnt_nxt = '0;
    if (!select_n_in) begin
      echo_cnt_nxt = echo_full ? echo_cnt_r : echo_cnt_r + ECHO_CNT_W'(1);
    end
  end

  always_ff @(posedge shift_clk_in) begin
    if (rst_link) begin
      echo_cnt_r <= '0;
    end else begin
      echo_cnt_r <= echo_cnt_nxt;
    end
  end

  a_load_input: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_end && f_cmd == `QDSL_CMD_LOAD_IN |=> in_r[$past(f_addr)] == $past(f_code))
    else $error("input register not loaded");
  a_load_no_dac: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_end && f_cmd == `QDSL_CMD_LOAD_IN && strobe_n_s |=> $stable(dac_r))
    else $error("DAC register changed on input load");
  a_update_all: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_end && f_cmd == `QDSL_CMD_LOAD_UP && strobe_n_s |=> dac_r == in_r)
    else $error("DAC registers not updated");
  a_strobe_copy: assert property (@(posedge clk_in) disable iff (reset_in)
    !strobe_n_s |=> dac_r == $past(in_r))
    else $error("strobe did not copy input registers");
  a_reset_clear: assert property (@(posedge clk_in)
    reset_in |=> in_r == '0 && dac_r == '0 && edge_r == QDSL_EDGE_RISE)
    else $error("reset state wrong");
  a_oe_select: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(sel_n_s) |-> !serial_out_oe_out && serial_out)
    else $error("serial output not disabled");
  a_shift_in: assert property (@(posedge shift_clk_in) disable iff (rst_link)
    !select_n_in |=> shift_r[0] == $past(serial_in) && shift_r[1] == $past(shift_r[0]))
    else $error("serial bit not shifted in");
  a_shift_hold: assert property (@(posedge shift_clk_in) disable iff (rst_link || reset_in)
    select_n_in |=> $stable(shift_r))
    else $error("shift register moved while deselected");
  a_echo_rise: assert property (@(posedge shift_clk_in) disable iff (rst_link || reset_in)
    echo_full && !edge_link |-> serial_out_oe_out == 1'b0 ||
      serial_out == $past(serial_in, `QDSL_FRAME_W))
    else $error("echo lag wrong");

  c_load_input: cover property (@(posedge clk_in) frame_end && f_cmd == `QDSL_CMD_LOAD_IN);
  c_update_all: cover property (@(posedge clk_in) frame_end && f_cmd == `QDSL_CMD_LOAD_UP);
  c_strobe:     cover property (@(posedge clk_in) $fell(strobe_n_s));
  c_edge_fall:  cover property (@(posedge clk_in) $rose(edge_r));
endmodule : qdsl_top
`default_nettype wire

// ==== common/qdsl_map.svh ====
// Frame layout, command codes and reset values of the quad DAC serial loader
`ifndef QDSL_MAP_SVH
`define QDSL_MAP_SVH
`define QDSL_FRAME_W     16
`define QDSL_CODE_W      12
`define QDSL_CHANNELS    4
`define QDSL_SYNC_STAGES 2
`define QDSL_ADDR_MSB    15
`define QDSL_ADDR_LSB    14
`define QDSL_CMD_MSB     13
`define QDSL_CMD_LSB     12
`define QDSL_CODE_MSB    11
`define QDSL_CMD_SPECIAL 2'h0
`define QDSL_CMD_LOAD_IN 2'h1
`define QDSL_CMD_NOP     2'h2
`define QDSL_CMD_LOAD_UP 2'h3
`define QDSL_ADDR_FALL   2'h2
`define QDSL_ADDR_RISE   2'h3
`define QDSL_CODE_RESET  12'h000
`define QDSL_FRAME_RESET 16'h0000
`endif

// ==== common/qdsl_pkg.sv ====
// Types shared by the quad DAC serial loader
`default_nettype none
package qdsl_pkg;
  typedef enum logic {
    QDSL_EDGE_RISE = 1'b0,
    QDSL_EDGE_FALL = 1'b1
  } qdsl_edge_t;
  typedef logic [1:0]  qdsl_chan_t;
  typedef logic [1:0]  qdsl_cmd_t;
endpackage : qdsl_pkg
`default_nettype wire

// ==== hw/qdsl_sync.sv ====
// Two-stage level synchroniser, any width
`timescale 1ns/1ns
`default_nettype none
module qdsl_sync #(
  parameter int WIDTH    = 1,
  parameter int RESET_VAL = 0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_r <= WIDTH'(RESET_VAL);
      sync_r <= WIDTH'(RESET_VAL);
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : qdsl_sync
`default_nettype wire

// ==== tb/qdsl_host_model.sv ====
// Host side serial master model for the quad DAC serial loader
`timescale 1ns/1ns
`default_nettype none
module qdsl_host_model (
  output logic      shift_clk_out,
  output logic      select_n_out,
  output logic      data_out,
  input  wire logic echo_in
);
  // ==========================================
  // Link driving
  initial begin
    shift_clk_out = 1'b0;
    select_n_out  = 1'b1;
    data_out      = 1'b0;
  end

  task automatic pulses(input int n);
    repeat (n) begin
      #24 shift_clk_out = 1'b1;
      #24 shift_clk_out = 1'b0;
    end
  endtask : pulses

  // Echo bit taken just before each rising shift edge
  task automatic send(input logic [15:0] word, output logic [15:0] echo);
    select_n_out = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      data_out = word[i];
      #24 echo[i] = echo_in;
      shift_clk_out = 1'b1;
      #24 shift_clk_out = 1'b0;
    end
    #24 select_n_out = 1'b1;
    data_out = ~word[0];
  endtask : send
endmodule : qdsl_host_model
`default_nettype wire

// ==== tb/tb_quad_dac_serial_loader.sv ====
// Self-checking bench of the quad DAC serial loader
`timescale 1ns/1ns
`default_nettype none
`include "qdsl_map.svh"
module tb_quad_dac_serial_loader
  import qdsl_pkg::*;
;
  logic             clk_in   = 1'b0;
  logic             reset_in = 1'b1;
  logic             load_n   = 1'b1;
  wire logic        shift_clk;
  wire logic        select_n;
  wire logic        ser_in;
  logic             ser_out;
  logic             ser_oe;
  logic [3:0][11:0] dac;
  qdsl_edge_t       edge_s;
  logic [15:0]      echo;
  logic [15:0]      last;
  logic [3:0][11:0] code_tab = {12'hFFF, 12'h789, 12'h456, 12'h123};
  int               fail_count  = 0;
  int               check_count = 0;

  always #25 clk_in = ~clk_in;

  qdsl_host_model u_qdsl_host_model (.shift_clk_out(shift_clk), .select_n_out(select_n),
    .data_out(ser_in), .echo_in(ser_out));

  qdsl_top u_qdsl_top (.clk_in(clk_in), .reset_in(reset_in), .shift_clk_in(shift_clk),
    .select_n_in(select_n), .serial_in(ser_in), .load_all_strobe_n_in(load_n),
    .serial_out(ser_out), .serial_out_oe_out(ser_oe), .dac_codes_out(dac), .out_edge_out(edge_s));

  // ==========================================
  // Checking and closing
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic frame(input qdsl_chan_t ch, input qdsl_cmd_t cmd, input logic [11:0] code);
    u_qdsl_host_model.send({ch, cmd, code}, echo);
    repeat (6) @(posedge clk_in);
    #1 check(48'(echo), 48'(last));
    last = {ch, cmd, code};
  endtask : frame

  initial begin
    #100000 fail_count++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    fork
      u_qdsl_host_model.pulses(3);
      begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
      end
    join
    u_qdsl_host_model.pulses(3);
    check(dac, '0);
    check(48'(edge_s), 48'(QDSL_EDGE_RISE));
    check(48'({ser_oe, ser_out}), 48'h1);
    last = '0;
    for (int c = 0; c < 4; c++) begin
      frame(qdsl_chan_t'(c), `QDSL_CMD_LOAD_IN, code_tab[c]);
      check(dac, '0);
    end
    @(posedge clk_in) load_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1 check(dac, code_tab);
    @(posedge clk_in) load_n <= 1'b1;
    frame(2'h0, `QDSL_CMD_NOP, 12'hAAA);
    check(dac, code_tab);
    frame(2'h1, `QDSL_CMD_LOAD_IN, 12'h555);
    check(dac, code_tab);
    frame(`QDSL_ADDR_FALL, `QDSL_CMD_SPECIAL, 12'h000);
    code_tab[1] = 12'h555;
    check(dac, code_tab);
    check(48'(edge_s), 48'(QDSL_EDGE_FALL));
    frame(`QDSL_ADDR_RISE, `QDSL_CMD_SPECIAL, 12'h000);
    check(48'(edge_s), 48'(QDSL_EDGE_RISE));
    frame(2'h3, `QDSL_CMD_LOAD_UP, 12'h000);
    code_tab[3] = 12'h000;
    check(dac, code_tab);
    tally_and_finish();
  end
endmodule : tb_quad_dac_serial_loader
`default_nettype wire
